// ===== core/fsr_stall_reinit.sv
// Function
// - one bus clock launches and captures everything
// - all timing on bus clock rising edge
// - drive reinit on bus error when enabled
// - asserted reinit means bus info untrusted
// - observed reinit resets lock and arbitration
// - in-order queue and trackers left untouched
// - after reinit re-arbitrate then drain queues
// - reinit line is wired-or shared
// - reinit driven and sampled on designated edges
// - unable to accept asserts block-next-request
// - no new transaction while bus stalled
// - block-next-request line is wired-or shared
// - block-next-request on designated edges only
module fsr_stall_reinit (
    input wire logic bus_clock_positive_leg,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire fsr_pkg::fsr_strap_t strap,
    input wire fsr_pkg::fsr_req_t req,
    input wire logic arb_granted,
    input wire logic queues_empty,
    input wire logic bus_reinit_n_i,
    output fsr_pkg::fsr_od_t bus_reinit_n_o,
    input wire logic block_next_request_n_i,
    output fsr_pkg::fsr_od_t block_next_request_n_o,
    output fsr_pkg::fsr_ctl_t ctl
);

    logic [1:0] phase_reg;
    logic strap_done_reg;
    fsr_pkg::fsr_strap_t strap_reg;
    logic err_pend_reg;
    logic reinit_drv_reg;
    logic bnr_drv_reg;
    logic reinit_smp_reg;
    logic bnr_smp_reg;
    logic reinit_pulse_reg;
    fsr_pkg::fsr_state_t state_reg;
    fsr_pkg::fsr_state_t state_next;
    logic drive_edge;
    logic sample_edge;

    assign drive_edge = (phase_reg == fsr_pkg::DRIVE_PHASE);
    assign sample_edge = (phase_reg == fsr_pkg::SAMPLE_PHASE);

    // everything runs on the positive bus clock leg rising edge
    always_ff @(posedge bus_clock_positive_leg or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= 2'h0;
        end else if (clk_en) begin
            phase_reg <= (phase_reg == fsr_pkg::PHASE_LAST) ? 2'h0 : phase_reg + 2'h1;
        end
    end

    // straps caught on the first enabled edge after reset release
    always_ff @(posedge bus_clock_positive_leg or negedge arst_n) begin
        if (!arst_n) begin
            strap_done_reg <= 1'b0;
            strap_reg <= '0;
        end else if (clk_en && !strap_done_reg) begin
            strap_done_reg <= 1'b1;
            strap_reg <= strap;
        end
    end

    // bus error held until launched on a drive edge; a new error wins over the clear
    always_ff @(posedge bus_clock_positive_leg or negedge arst_n) begin
        if (!arst_n) begin
            err_pend_reg <= 1'b0;
        end else if (clk_en) begin
            if (req.bus_error && strap_reg.reinit_drive_en) begin
                err_pend_reg <= 1'b1;
            end else if (drive_edge) begin
                err_pend_reg <= 1'b0;
            end
        end
    end

    // pin drivers change only on drive edges
    always_ff @(posedge bus_clock_positive_leg or negedge arst_n) begin
        if (!arst_n) begin
            reinit_drv_reg <= 1'b0;
            bnr_drv_reg <= 1'b0;
        end else if (clk_en && drive_edge) begin
            reinit_drv_reg <= err_pend_reg && strap_reg.reinit_drive_en;
            bnr_drv_reg <= req.cannot_accept;
        end
    end

    // open drain: output level always low, enable pulls the wired-or
    assign bus_reinit_n_o.o = 1'b0;
    assign bus_reinit_n_o.oe = reinit_drv_reg;
    assign block_next_request_n_o.o = 1'b0;
    assign block_next_request_n_o.oe = bnr_drv_reg;

    // sampled only on sample edges; low from any agent reads asserted
    always_ff @(posedge bus_clock_positive_leg or negedge arst_n) begin
        if (!arst_n) begin
            reinit_smp_reg <= 1'b0;
            bnr_smp_reg <= 1'b0;
            reinit_pulse_reg <= 1'b0;
        end else if (clk_en) begin
            reinit_pulse_reg <= 1'b0;
            if (sample_edge) begin
                reinit_smp_reg <= !bus_reinit_n_i;
                bnr_smp_reg <= !block_next_request_n_i;
                reinit_pulse_reg <= !bus_reinit_n_i && strap_reg.reinit_observe_en;
            end
        end
    end

    // recovery sequence; queue contents are never cleared here
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            fsr_pkg::FSR_IDLE: begin
                if (reinit_pulse_reg) begin
                    state_next = fsr_pkg::FSR_REARB;
                end
            end
            fsr_pkg::FSR_REARB: begin
                // a fresh reinit restarts arbitration even if a grant arrives with it
                if (reinit_pulse_reg) begin
                    state_next = fsr_pkg::FSR_REARB;
                end else if (arb_granted) begin
                    state_next = fsr_pkg::FSR_DRAIN;
                end
            end
            fsr_pkg::FSR_DRAIN: begin
                if (reinit_pulse_reg) begin
                    state_next = fsr_pkg::FSR_REARB;
                end else if (queues_empty) begin
                    state_next = fsr_pkg::FSR_IDLE;
                end
            end
            default: state_next = fsr_pkg::FSR_IDLE;
        endcase
    end

    always_ff @(posedge bus_clock_positive_leg or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= fsr_pkg::FSR_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        ctl.reset_lock_track = reinit_pulse_reg;
        ctl.reset_arb_fsm = reinit_pulse_reg;
        ctl.rearbitrate = (state_reg == fsr_pkg::FSR_REARB);
        ctl.stalled = bnr_smp_reg;
        // no issue while stalled or while re-arbitrating
        ctl.issue_ok = req.want_issue && !bnr_smp_reg && (state_reg != fsr_pkg::FSR_REARB);
        ctl.reinit_seen = reinit_smp_reg;
    end

endmodule

// ===== core/fsr_pkg.sv
package fsr_pkg;

    // index of the designated edge within a drive/sample cycle of the wired-or lines
    localparam int unsigned PHASE_W = 2;
    localparam logic [1:0] DRIVE_PHASE = 2'h0;
    localparam logic [1:0] SAMPLE_PHASE = 2'h2;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // power-on straps
    typedef struct packed {
        logic reinit_drive_en;
        logic reinit_observe_en;
    } fsr_strap_t;

    // requests from the processor bus unit
    typedef struct packed {
        logic bus_error;
        logic cannot_accept;
        logic want_issue;
    } fsr_req_t;

    // open-drain pin as two signals
    typedef struct packed {
        logic o;
        logic oe;
    } fsr_od_t;

    // outward control to the bus unit
    typedef struct packed {
        logic reset_lock_track;
        logic reset_arb_fsm;
        logic rearbitrate;
        logic issue_ok;
        logic stalled;
        logic reinit_seen;
    } fsr_ctl_t;

    typedef enum logic [2:0] {
        FSR_IDLE = 3'h1,
        FSR_REARB = 3'h2,
        FSR_DRAIN = 3'h4
    } fsr_state_t;

endpackage

// ===== dv/fsr_stall_reinit_monitor.sv
module fsr_stall_reinit_monitor (
    input wire logic bus_clock_positive_leg,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire fsr_pkg::fsr_strap_t strap,
    input wire fsr_pkg::fsr_req_t req,
    input wire logic block_next_request_n_i,
    input wire fsr_pkg::fsr_od_t bus_reinit_n_o,
    input wire fsr_pkg::fsr_od_t block_next_request_n_o,
    input wire fsr_pkg::fsr_ctl_t ctl
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge bus_clock_positive_leg); endclocking
    default disable iff (!arst_n);
    a_never_high: assert property (!bus_reinit_n_o.o && !block_next_request_n_o.o)
        else $error("pin driven high");
    a_bnr_set: assert property ((req.cannot_accept && clk_en)[*5] |-> block_next_request_n_o.oe)
        else $error("stall not driven");
    a_bnr_clear: assert property ((!req.cannot_accept && clk_en)[*5] |-> !block_next_request_n_o.oe)
        else $error("stall not released");
    a_stall_seen: assert property ((!block_next_request_n_i && clk_en)[*5] |-> ctl.stalled)
        else $error("stall not sampled");
    a_issue_gate: assert property (ctl.issue_ok == (req.want_issue && !ctl.stalled && !ctl.rearbitrate))
        else $error("issue while blocked");
    a_reinit_strap: assert property (bus_reinit_n_o.oe |-> strap.reinit_drive_en)
        else $error("reinit driven unstrapped");
    a_pulse_gate: assert property (ctl.reset_lock_track |-> strap.reinit_observe_en && ctl.reset_arb_fsm)
        else $error("bad reset pulse");
    a_rearb_next: assert property (ctl.reset_arb_fsm |-> ##[1:2] ctl.rearbitrate)
        else $error("no rearbitration");
    c_pulse: cover property (ctl.reset_arb_fsm);
    c_stall: cover property (ctl.stalled && req.want_issue);
    c_drive: cover property (bus_reinit_n_o.oe);
endmodule

bind fsr_stall_reinit fsr_stall_reinit_monitor i_mon (.bus_clock_positive_leg, .arst_n, .clk_en, .strap, .req,
    .block_next_request_n_i, .bus_reinit_n_o, .block_next_request_n_o, .ctl);

// ===== dv/fsr_agent_model.sv
module fsr_agent_model (
    input wire logic clk,
    input wire logic [1:0] pull,
    input wire logic [1:0] dut_oe,
    output logic [1:0] line_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] own_oe = 2'h0;
    always_ff @(posedge clk) own_oe <= pull;
    // pull-up when nobody pulls low
    assign line_n = ~(own_oe | dut_oe);
endmodule

// ===== dv/fsr_stall_reinit_tb.sv
module fsr_stall_reinit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, arst_n = 0, clk_en = 1, granted = 0, q_empty = 0;
    logic [1:0] pull = 2'h0, line_n;
    fsr_pkg::fsr_strap_t strap = 2'h3;
    fsr_pkg::fsr_req_t req = 3'h1;
    fsr_pkg::fsr_od_t ri_o, bnr_o;
    fsr_pkg::fsr_ctl_t ctl;
    int miscompares = 0, n_tests = 0, np = 0, no = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        np += ctl.reset_lock_track;
        no += ri_o.oe;
    end
    fsr_stall_reinit i_fsr_stall_reinit (.bus_clock_positive_leg(clk), .arst_n(arst_n), .clk_en(clk_en),
        .strap(strap), .req(req), .arb_granted(granted), .queues_empty(q_empty), .bus_reinit_n_i(line_n[1]),
        .bus_reinit_n_o(ri_o), .block_next_request_n_i(line_n[0]), .block_next_request_n_o(bnr_o), .ctl(ctl));
    fsr_agent_model i_fsr_agent_model (.clk(clk), .pull(pull), .dut_oe({ri_o.oe, bnr_o.oe}), .line_n(line_n));
    task w(int n);
        repeat (n) @(negedge clk);
    endtask
    task chk(string nm, logic e, logic g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask
    task rst(logic [1:0] s);
        arst_n = 0;
        strap = s;
        w(2);
        np = 0;
        no = 0;
        arst_n = 1;
    endtask
    task t_stall;
        req.cannot_accept = 1;
        w(6);
        chk("bnr_oe", 1, bnr_o.oe);
        chk("issue_ok", 0, ctl.issue_ok);
        req.cannot_accept = 0;
        pull = 2'h1;
        w(6);
        chk("bnr_oe", 0, bnr_o.oe);
        chk("stalled", 1, ctl.stalled);
        pull = 2'h0;
        w(6);
        chk("issue_ok", 1, ctl.issue_ok);
    endtask
    task t_reinit;
        req.bus_error = 1;
        w(1);
        req.bus_error = 0;
        w(10);
        chk("oe_cycles", 1, no == 4);
        chk("pulses", 1, np == 1);
        chk("rearb", 1, ctl.rearbitrate);
        granted = 1;
        w(2);
        chk("rearb", 0, ctl.rearbitrate);
        granted = 0;
        q_empty = 1;
        w(2);
        chk("issue_ok", 1, ctl.issue_ok);
    endtask
    task t_nostrap;
        rst(2'h0);
        req.bus_error = 1;
        pull = 2'h2;
        w(6);
        chk("seen", 1, ctl.reinit_seen);
        chk("oe_cycles", 1, no == 0);
        chk("pulses", 1, np == 0);
        req.bus_error = 0;
        pull = 2'h0;
    endtask
    task t_freeze;
        clk_en = 0;
        pull = 2'h1;
        w(8);
        chk("stalled", 0, ctl.stalled);
        clk_en = 1;
        w(6);
        chk("stalled", 1, ctl.stalled);
        pull = 2'h0;
    endtask
    task results;
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        rst(2'h3);
        t_stall;
        t_reinit;
        t_nostrap;
        t_freeze;
        results;
    end
    initial begin
        #5000;
        miscompares++;
        results;
    end
endmodule
